// [gpio_mux_pkg.sv]
// package: register map, pin assignments, reset defaults and types of the pin mux
package gpio_mux_pkg;

  localparam int          NUM_PINS = 13;

  // pin indices
  localparam int          PIN_WAKE_IN   = 0;
  localparam int          PIN_WAKE_STAT = 1;
  localparam int          PIN_LED0      = 2;
  localparam int          PIN_LED1      = 3;
  localparam int          PIN_HOST_WAKE = 4;
  localparam int          PIN_TX        = 6;
  localparam int          PIN_RX        = 7;
  localparam int          PIN_RTS       = 8;
  localparam int          PIN_CTS       = 9;

  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_GPIO_DO = 8'h08;
  localparam logic [7:0]  OFS_GPIO_OE = 8'h0c;
  localparam logic [7:0]  OFS_GPIO_DI = 8'h10;
  localparam logic [7:0]  OFS_PIN0    = 8'h20;  // pin n at OFS_PIN0 + 4*n
  localparam logic [7:0]  OFS_PIN_END = 8'h54;  // one word past pin 12 at 8'h50

  // control register fields
  localparam int          CTRL_BOOT_DONE = 0;
  localparam int          CTRL_PIN_CFG   = 1;
  localparam int          CTRL_SLEEP     = 2;
  localparam int          CTRL_WAKE_EN   = 3;
  localparam int          CTRL_LED0_EN   = 4;
  localparam int          CTRL_LED1_EN   = 5;
  localparam int          CTRL_HWAKE_EN  = 6;
  localparam int          CTRL_HWAKE_VAL = 7;
  localparam int          CTRL_LED0_VAL  = 8;
  localparam int          CTRL_LED1_VAL  = 9;

  // status register fields
  localparam int          STAT_SLEEP    = 0;
  localparam int          STAT_BOOTED   = 1;
  localparam int          STAT_CFG_DONE = 2;

  // drive strength codes
  localparam logic [1:0]  DRV_1MA = 2'h0;
  localparam logic [1:0]  DRV_2MA = 2'h1;
  localparam logic [1:0]  DRV_4MA = 2'h2;

  // pull codes
  localparam logic [1:0]  PULL_NONE = 2'h0;
  localparam logic [1:0]  PULL_UP   = 2'h1;
  localparam logic [1:0]  PULL_DOWN = 2'h2;

  // reset defaults: bit set means output / pull-up for that pin; in BOOT_MASK a set bit marks a boot-assigned pin
  localparam logic [12:0] RST_OUT_MASK  = 13'h0142;  // pins 1, 6, 8
  localparam logic [12:0] RST_PULL_MASK = 13'h1c3c;  // pins 2-5, 10-12
  localparam logic [12:0] BOOT_MASK     = 13'h03c2;  // pins 1, 6-9

  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;

  // per-pin pad attributes
  typedef struct packed {
    logic       oe;
    logic [1:0] pull;
    logic [1:0] drive;
  } pad_cfg_t;

  // serial link signals as seen by the core
  typedef struct packed {
    logic tx;
    logic request_to_send_n;
  } link_out_t;

  typedef struct packed {
    logic rx;
    logic clear_to_send_n;
  } link_in_t;

endpackage : gpio_mux_pkg

// [gpio_function_mux.sv]
// pin function multiplexer for i/o pins 0..12 with an axi4-lite register slave
`timescale 1ns/1ps
module gpio_function_mux (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [7:0]                        s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [7:0]                        s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic [12:0]                       pin_in,
  output logic [12:0]                            pin_out,
  output logic [12:0]                            pin_oe,
  output gpio_mux_pkg::pad_cfg_t [12:0]          pad_cfg,
  input  wire gpio_mux_pkg::link_out_t           link_out,
  output gpio_mux_pkg::link_in_t                 link_in,
  output logic                                   sleep_mode,
  output logic                                   wake_event
);

  logic [9:0]  ctrl_q;
  logic [12:0] gpio_do_q;
  logic [12:0] gpio_oe_q;
  logic [12:0] pull_up_q;
  logic [12:0] pull_dn_q;
  logic [1:0]  drive_q [13];
  logic        sleep_q;
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        boot_done, pin_cfg, wr_go;
  logic [12:0] gp_mask;

  // decode a pin attribute register address into its pin index, or 13 if none
  function automatic logic [3:0] pin_index(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - gpio_mux_pkg::OFS_PIN0;
    if (addr >= gpio_mux_pkg::OFS_PIN0 && addr < gpio_mux_pkg::OFS_PIN_END && addr[1:0] == 2'h0)
      pin_index = rel[5:2];
    else
      pin_index = 4'hd;
  endfunction : pin_index

  // write byte lanes merged into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) merge[8*i +: 8] = nw[8*i +: 8];
  endfunction : merge

  assign boot_done = ctrl_q[gpio_mux_pkg::CTRL_BOOT_DONE];
  assign pin_cfg   = ctrl_q[gpio_mux_pkg::CTRL_PIN_CFG];
  // pins that act as plain gpio once configured
  assign gp_mask   = ~(gpio_mux_pkg::BOOT_MASK) & 13'h1c20;

  // ---------------- axi4-lite write channel ----------------
  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready  = ~w_q & ~bvalid_q;
  assign wr_go         = aw_q & w_q & ~bvalid_q;

  // address and data may arrive in either order; each is latched alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= gpio_mux_pkg::AXI_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      if (awaddr_q == gpio_mux_pkg::OFS_CTRL || awaddr_q == gpio_mux_pkg::OFS_GPIO_DO ||
          awaddr_q == gpio_mux_pkg::OFS_GPIO_OE || pin_index(awaddr_q) != 4'hd)
        bresp_q <= gpio_mux_pkg::AXI_OKAY;
      else
        bresp_q <= gpio_mux_pkg::AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // control register: boot done and pin configuration are sticky once set
  always_ff @(posedge aclk) begin
    logic [31:0] nw;
    nw = merge({22'h0, ctrl_q}, wdata_q, wstrb_q);
    if (!aresetn) begin
      ctrl_q <= 10'h000;
    end else if (wr_go && awaddr_q == gpio_mux_pkg::OFS_CTRL) begin
      ctrl_q <= nw[9:0];
      ctrl_q[gpio_mux_pkg::CTRL_BOOT_DONE] <= boot_done | nw[gpio_mux_pkg::CTRL_BOOT_DONE];
      ctrl_q[gpio_mux_pkg::CTRL_PIN_CFG]   <= pin_cfg | nw[gpio_mux_pkg::CTRL_PIN_CFG];
    end
  end

  // sleep state: software enters sleep, an enabled wake input leaves it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_q <= 1'b0;
    end else if (wake_event) begin
      sleep_q <= 1'b0;
    end else if (wr_go && awaddr_q == gpio_mux_pkg::OFS_CTRL && wstrb_q[0]) begin
      sleep_q <= wdata_q[gpio_mux_pkg::CTRL_SLEEP];
    end
  end

  // wake wins over a same-cycle sleep request so an edge is never lost
  assign wake_event = sleep_q & pin_cfg & ctrl_q[gpio_mux_pkg::CTRL_WAKE_EN]
                      & pin_in[gpio_mux_pkg::PIN_WAKE_IN];
  assign sleep_mode = sleep_q;

  // per pin gpio data, direction, pull and drive registers
  always_ff @(posedge aclk) begin
    logic [3:0]  idx;
    logic [31:0] nw;
    idx = pin_index(awaddr_q);
    nw  = merge(32'h0, wdata_q, wstrb_q);
    if (!aresetn) begin
      gpio_do_q <= 13'h0000;
      gpio_oe_q <= gpio_mux_pkg::RST_OUT_MASK;
      pull_up_q <= gpio_mux_pkg::RST_PULL_MASK;
      pull_dn_q <= 13'h0000;
      for (int i = 0; i < gpio_mux_pkg::NUM_PINS; i++)
        drive_q[i] <= gpio_mux_pkg::DRV_1MA;
    end else if (wr_go) begin
      if (awaddr_q == gpio_mux_pkg::OFS_GPIO_DO)
        gpio_do_q <= 13'(merge({19'h0, gpio_do_q}, wdata_q, wstrb_q));
      if (awaddr_q == gpio_mux_pkg::OFS_GPIO_OE)
        gpio_oe_q <= 13'(merge({19'h0, gpio_oe_q}, wdata_q, wstrb_q));
      if (idx != 4'hd && wstrb_q[0]) begin
        pull_up_q[idx] <= nw[2:1] == gpio_mux_pkg::PULL_UP;
        pull_dn_q[idx] <= nw[2:1] == gpio_mux_pkg::PULL_DOWN;
        drive_q[idx]   <= (nw[4:3] == 2'h3) ? gpio_mux_pkg::DRV_4MA : nw[4:3];
      end
    end
  end

  // ---------------- pin function mux ----------------
  always_comb begin
    pin_out = gpio_do_q;
    pin_oe  = gpio_oe_q;
    // before configuration, unassigned pins stay at their reset direction
    if (!pin_cfg) begin
      pin_oe  = gpio_mux_pkg::RST_OUT_MASK & ~gpio_mux_pkg::BOOT_MASK;
      pin_out = 13'h0000;
    end else begin
      pin_oe  = gpio_oe_q & gp_mask;
      pin_out = gpio_do_q & gp_mask;
      pin_oe[gpio_mux_pkg::PIN_WAKE_IN] = ~ctrl_q[gpio_mux_pkg::CTRL_WAKE_EN]
                                          & gpio_oe_q[gpio_mux_pkg::PIN_WAKE_IN];
      pin_out[gpio_mux_pkg::PIN_WAKE_IN] = gpio_do_q[gpio_mux_pkg::PIN_WAKE_IN];
      pin_oe[gpio_mux_pkg::PIN_LED0]  = ctrl_q[gpio_mux_pkg::CTRL_LED0_EN];
      pin_out[gpio_mux_pkg::PIN_LED0] = ctrl_q[gpio_mux_pkg::CTRL_LED0_VAL];
      pin_oe[gpio_mux_pkg::PIN_LED1]  = ctrl_q[gpio_mux_pkg::CTRL_LED1_EN];
      pin_out[gpio_mux_pkg::PIN_LED1] = ctrl_q[gpio_mux_pkg::CTRL_LED1_VAL];
      pin_oe[gpio_mux_pkg::PIN_HOST_WAKE]  = ctrl_q[gpio_mux_pkg::CTRL_HWAKE_EN];
      pin_out[gpio_mux_pkg::PIN_HOST_WAKE] = ctrl_q[gpio_mux_pkg::CTRL_HWAKE_VAL];
    end
    // boot-assigned pins; outputs are driven from reset, functions after boot
    pin_oe[gpio_mux_pkg::PIN_WAKE_STAT] = 1'b1;
    pin_oe[gpio_mux_pkg::PIN_TX]        = 1'b1;
    pin_oe[gpio_mux_pkg::PIN_RTS]       = 1'b1;
    pin_oe[gpio_mux_pkg::PIN_RX]        = 1'b0;
    pin_oe[gpio_mux_pkg::PIN_CTS]       = 1'b0;
    pin_out[gpio_mux_pkg::PIN_RX]       = 1'b0;
    pin_out[gpio_mux_pkg::PIN_CTS]      = 1'b0;
    pin_out[gpio_mux_pkg::PIN_WAKE_STAT] = boot_done ? sleep_q : 1'b0;
    pin_out[gpio_mux_pkg::PIN_TX]  = boot_done ? link_out.tx : 1'b1;
    pin_out[gpio_mux_pkg::PIN_RTS] = boot_done ? link_out.request_to_send_n : 1'b1;
  end

  // receive side; idle-high values until boot so the link sees no false start
  assign link_in.rx              = boot_done ? pin_in[gpio_mux_pkg::PIN_RX] : 1'b1;
  assign link_in.clear_to_send_n = boot_done ? pin_in[gpio_mux_pkg::PIN_CTS] : 1'b1;

  // pad attribute vector; pull and drive come from the pin registers for every pin, boot pins included
  always_comb begin
    for (int i = 0; i < gpio_mux_pkg::NUM_PINS; i++) begin
      pad_cfg[i].oe    = pin_oe[i];
      pad_cfg[i].drive = drive_q[i];
      pad_cfg[i].pull  = pull_up_q[i] ? gpio_mux_pkg::PULL_UP :
                         pull_dn_q[i] ? gpio_mux_pkg::PULL_DOWN : gpio_mux_pkg::PULL_NONE;
    end
  end

  // ---------------- axi4-lite read channel ----------------
  assign s_axi_arready = ~rvalid_q;

  always_ff @(posedge aclk) begin
    logic [3:0] idx;
    idx = pin_index(s_axi_araddr);
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= gpio_mux_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= gpio_mux_pkg::AXI_OKAY;
      rdata_q  <= 32'h0000_0000;
      case (s_axi_araddr)
        gpio_mux_pkg::OFS_CTRL:    rdata_q <= {22'h0, ctrl_q[9:3], sleep_q, ctrl_q[1:0]};
        gpio_mux_pkg::OFS_STATUS:  rdata_q <= {29'h0, pin_cfg, boot_done, sleep_q};
        gpio_mux_pkg::OFS_GPIO_DO: rdata_q <= {19'h0, gpio_do_q};
        gpio_mux_pkg::OFS_GPIO_OE: rdata_q <= {19'h0, gpio_oe_q};
        gpio_mux_pkg::OFS_GPIO_DI: rdata_q <= {19'h0, pin_in};
        default: begin
          if (idx != 4'hd)
            rdata_q <= {27'h0, drive_q[idx], pad_cfg[idx].pull, pin_oe[idx]};
          else
            rresp_q <= gpio_mux_pkg::AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : gpio_function_mux

// [gpio_mux_asserts.sv]
// checker: routing, direction and wake assertions at the pin mux ports
`timescale 1ns/1ps
module gpio_mux_asserts (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic [7:0]              s_axi_awaddr,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic [31:0]             s_axi_wdata,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic [12:0]             pin_in,
  input wire logic [12:0]             pin_out,
  input wire logic [12:0]             pin_oe,
  input wire gpio_mux_pkg::link_out_t link_out,
  input wire gpio_mux_pkg::link_in_t  link_in,
  input wire logic                    sleep_mode,
  input wire logic                    wake_event
);
  logic pend_q;
  logic booted_q;
  // boot write seen on the bus; assumes address and data are taken together
  always_ff @(posedge aclk) begin
    if (!aresetn) pend_q <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
             s_axi_awaddr == gpio_mux_pkg::OFS_CTRL && s_axi_wdata[0]) pend_q <= 1'b1;
  end
  // boot counts only after its response, when the register has landed
  always_ff @(posedge aclk) begin
    if (!aresetn) booted_q <= 1'b0;
    else if (pend_q && s_axi_bvalid) booted_q <= 1'b1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_woken;
    wake_event ##1 !sleep_mode;
  endsequence
  a_wake_ends_sleep: assert property (wake_event |-> s_woken)
    else $error("wake event did not end sleep");
  a_wake_cause: assert property (wake_event |-> sleep_mode && pin_in[0])
    else $error("wake event without sleep and pin 0 high");
  a_boot_pins_out: assert property (pin_oe[1] && pin_oe[6] && pin_oe[8])
    else $error("pins 1 6 8 not driven");
  a_wake_stat_pin: assert property (booted_q |-> pin_out[1] == sleep_mode)
    else $error("pin 1 differs from sleep state");
  a_tx_route: assert property (booted_q |-> pin_out[6] == link_out.tx)
    else $error("pin 6 not transmit");
  a_rts_route: assert property (booted_q |-> pin_out[8] == link_out.request_to_send_n)
    else $error("pin 8 not request to send");
  a_rx_route: assert property (booted_q |-> link_in.rx == pin_in[7])
    else $error("receive not from pin 7");
  a_cts_route: assert property (booted_q |-> link_in.clear_to_send_n == pin_in[9])
    else $error("clear to send not from pin 9");
endmodule : gpio_mux_asserts

bind gpio_function_mux gpio_mux_asserts chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .pin_in, .pin_out,
  .pin_oe, .link_out, .link_in, .sleep_mode, .wake_event);

// [host_link_model.sv]
// host side model: receive, clear-to-send and wake lines
`timescale 1ns/1ps
module host_link_model (
  input  wire logic aclk,
  input  wire logic tx,
  input  wire logic rts_n,
  input  wire logic slow,
  input  wire logic wake_req,
  output logic      rx,
  output logic      cts_n,
  output logic      wake
);
  logic [7:0] lfsr_q = 8'h5a;
  // receive line takes a new pseudo-random bit every cycle so a stale route cannot pass
  always_ff @(posedge aclk) begin
    lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ tx};
  end
  assign rx    = lfsr_q[0];
  // a slow host keeps clear-to-send off even when asked
  assign cts_n = slow | rts_n;
  // wake idles low, as the board pull-down holds it when unused
  assign wake  = wake_req;
endmodule : host_link_model

// [tb_top.sv]
// testbench: pin mux over axi4-lite beside a host link model
`timescale 1ns/1ps
module tb_top;
  logic                          aclk = 1'b0;
  logic                          aresetn = 1'b0;
  logic [7:0]                    aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0]                   w_d = 32'h0, r_d, rv;
  logic                          aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic                          aw_rdy, w_rdy, b_v, ar_rdy, r_v, sl_mode, wk_ev;
  logic [1:0]                    b_resp, r_resp, rs;
  logic [12:0]                   pins = 13'h0, p_out, p_oe, pin_in, goe, gdo, m;
  gpio_mux_pkg::pad_cfg_t [12:0] pads;
  gpio_mux_pkg::link_out_t       lo = '0;
  gpio_mux_pkg::link_in_t        li;
  logic                          slow = 0, wake_req = 0, h_rx, h_cts_n, h_wake;
  int                            fails = 0, checks = 0, ctrl, sl, pull[13], drv[13];

  assign pin_in = {pins[12:10], h_cts_n, pins[8], h_rx, pins[6:1], h_wake};
  initial forever #10 aclk = ~aclk;
  gpio_function_mux uut (.aclk, .aresetn, .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .pin_in, .pin_out(p_out),
    .pin_oe(p_oe), .pad_cfg(pads), .link_out(lo), .link_in(li), .sleep_mode(sl_mode),
    .wake_event(wk_ev));
  host_link_model host (.aclk, .tx(p_out[6]), .rts_n(p_out[8]), .slow, .wake_req,
    .rx(h_rx), .cts_n(h_cts_n), .wake(h_wake));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad = ad || aw_rdy;
      wd = wd || w_rdy;
      aw_v <= !ad;
      w_v <= !wd;
    end
    do @(posedge aclk); while (!b_v);
    rs = b_resp;
    b_r <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do @(posedge aclk); while (!ar_rdy);
    ar_v <= 1'b0;
    do @(posedge aclk); while (!r_v);
    rv = r_d;
    rs = r_resp;
    r_r <= 1'b0;
  endtask : rd

  task automatic rnd;
    @(posedge aclk);
    pins <= 13'($urandom);
    lo <= 2'($urandom);
    slow <= 1'($urandom);
    @(posedge aclk);
  endtask : rnd

  // model of the pads, compared with the pin, link, sleep and pad ports at each result
  task automatic chk_pins;
    logic [12:0] eo;
    logic [12:0] ev;
    m = ctrl[3] ? 13'h1c20 : 13'h1c21;
    eo = gpio_mux_pkg::RST_OUT_MASK;
    if (ctrl[1]) eo = eo | (goe & m) | {ctrl[6:4], 2'b00};
    ev = (goe & gdo & m) | {8'h0, ctrl[7], ctrl[9], ctrl[8], 2'b00};
    ev[1] = ctrl[0] & sl[0];
    ev[6] = ctrl[0] ? lo.tx : 1'b1;
    ev[8] = ctrl[0] ? lo.request_to_send_n : 1'b1;
    #1;
    chk("pin_oe", p_oe, eo);
    chk("pin_out", p_out & eo, ev & eo);
    chk("link_in", li, ctrl[0] ? {pin_in[7], pin_in[9]} : 2'b11);
    chk("sleep", sl_mode, sl[0]);
    for (int n = 0; n < 13; n++) chk("pad_cfg", pads[n], {eo[n], 2'(pull[n]), 2'(drv[n])});
  endtask : chk_pins

  initial begin
    void'($urandom(99063));
    ctrl = 0;
    sl = 0;
    goe = 13'h1fff;
    gdo = 0;
    foreach (pull[n]) pull[n] = gpio_mux_pkg::RST_PULL_MASK[n];
    foreach (drv[n]) drv[n] = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk_pins;
    // gpio enable written before boot must stay ignored
    wr(gpio_mux_pkg::OFS_GPIO_OE, 32'h1fff);
    rnd;
    chk_pins;
    $display("test reset defaults done");
    ctrl = 1;
    wr(gpio_mux_pkg::OFS_CTRL, 32'h1);
    rd(gpio_mux_pkg::OFS_STATUS);
    chk("status", rv, 32'h2);
    repeat (4) begin
      rnd;
      chk_pins;
    end
    $display("test boot routing done");
    for (int n = 0; n < 13; n++) begin
      pull[n] = $urandom_range(2);
      drv[n] = $urandom_range(2);
      wr(8'(gpio_mux_pkg::OFS_PIN0 + 4 * n), {27'h0, 2'(drv[n]), 2'(pull[n]), 1'b0});
      rd(8'(gpio_mux_pkg::OFS_PIN0 + 4 * n));
      chk("pad_rd", rv, {27'h0, 2'(drv[n]), 2'(pull[n]), gpio_mux_pkg::RST_OUT_MASK[n]});
    end
    chk_pins;
    $display("test pad attributes done");
    repeat (4) begin
      gdo = 13'($urandom);
      goe = 13'($urandom);
      ctrl = 32'h3 | ($urandom & 32'h3f0);
      wr(gpio_mux_pkg::OFS_GPIO_DO, 32'(gdo));
      wr(gpio_mux_pkg::OFS_GPIO_OE, 32'(goe));
      wr(gpio_mux_pkg::OFS_CTRL, ctrl);
      rnd;
      chk_pins;
      rd(gpio_mux_pkg::OFS_GPIO_DI);
      chk("gpio_in", rv[12:0] & ~goe & m, pin_in & ~goe & m);
    end
    $display("test pin functions done");
    // sleep without wake enabled: pin 0 must not wake
    sl = 1;
    wr(gpio_mux_pkg::OFS_CTRL, ctrl | 32'h4);
    @(posedge aclk);
    wake_req <= 1'b1;
    repeat (3) @(posedge aclk);
    chk_pins;
    chk("wake_event", wk_ev, 1'b0);
    wake_req <= 1'b0;
    ctrl = ctrl | 32'h8;
    wr(gpio_mux_pkg::OFS_CTRL, ctrl | 32'h4);
    rd(gpio_mux_pkg::OFS_STATUS);
    chk("status", rv, 32'h7);
    @(posedge aclk);
    wake_req <= 1'b1;
    #1;
    chk("wake_event", wk_ev, 1'b1);
    @(posedge aclk);
    sl = 0;
    chk_pins;
    wake_req <= 1'b0;
    $display("test sleep and wake done");
    wr(8'h60, $urandom);
    chk("bresp", rs, gpio_mux_pkg::AXI_SLVERR);
    rd(8'h60);
    chk("rresp", rs, gpio_mux_pkg::AXI_SLVERR);
    chk_pins;
    $display("test unmapped access done");
    print_verdict;
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    print_verdict;
  end
endmodule : tb_top
